/* File: hw/asp_pkg.sv */
// Package for the asynchronous serial port: register map, fields, timing and carriers
package asp_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] ASP_CTRL_OFF = 4'h0;
	localparam logic [3:0] ASP_BUF_OFF = 4'h4;
	localparam logic [3:0] ASP_STAT_OFF = 4'h8;
	localparam logic [3:0] ASP_MASK_OFF = 4'hc;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int ASP_CTRL_MODE_LSB = 0;
	localparam int ASP_CTRL_MPM_BIT = 2;
	localparam int ASP_CTRL_TX9_BIT = 3;
	localparam int ASP_CTRL_RX9_BIT = 4;
	localparam int ASP_CTRL_HALF_BIT = 5;
	localparam logic [5:0] ASP_CTRL_RESET = 6'h00;

	// Status and mask fields
	localparam int ASP_ST_TX_BIT = 0;
	localparam int ASP_ST_RX_BIT = 1;
	localparam logic [1:0] ASP_STAT_RESET = 2'h0;
	localparam logic [1:0] ASP_MASK_RESET = 2'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [3:0] ASP_SAMPLE_A = 4'h7;
	localparam logic [3:0] ASP_SAMPLE_B = 4'h8;
	localparam logic [3:0] ASP_SAMPLE_C = 4'h9;
	localparam logic [3:0] ASP_LAST_STATE = 4'hf;
	localparam logic [4:0] ASP_FAST_DIV = 5'h0f;
	localparam logic [4:0] ASP_SLOW_DIV = 5'h1f;
	localparam logic [8:0] ASP_RX_PRESET = 9'h1ff;

	// Frame modes
	typedef enum logic [1:0] {
		ASP_MODE_TEN,
		ASP_MODE_ELEVEN_FIXED,
		ASP_MODE_ELEVEN_TIMER,
		ASP_MODE_SPARE
	} asp_mode_type;

	// Control fields carried together
	typedef struct packed {
		logic half_rate;
		logic rx_ninth_bit;
		logic tx_ninth_bit;
		logic multiproc_mode;
		asp_mode_type mode;
	} asp_ctrl_type;

	// Bus request carrier
	typedef struct packed {
		logic we;
		logic [3:0] addr;
		logic [31:0] dat;
	} asp_req_type;

endpackage

/* File: hw/asp_rx_filter.sv */
// Three-flop synchroniser and agreement filter for the receive pin
module asp_rx_filter
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and filtered level
	input wire logic pin_i,
	output logic level_o
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;

	// Idle line is high, so reset to one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level_reg <= 1'b1;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_reg <= s3_reg;
			end
		end
	end

	assign level_o = level_reg;

endmodule

/* File: hw/asp_core.sv */
// Asynchronous serial port: ten and eleven bit frames, Wishbone registers
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
module asp_core
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Baud sources
	input wire logic baud_tick_i,
	input wire logic timer_ovf_i,
	// Serial pins
	input wire logic rxd_i,
	output logic txd_o,
	// Interrupt
	output logic irq_o
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	asp_req_type req;
	logic ack_reg;
	logic [31:0] dat_reg;
	asp_ctrl_type ctrl_reg;
	logic [7:0] rbuf_reg;
	logic [1:0] stat_reg;
	logic [1:0] mask_reg;
	logic irq_reg;

	assign req = '{we: we_i, addr: adr_i, dat: dat_i};

	wire bus_go = cyc_i && stb_i && !ack_reg;
	wire wr_go = bus_go && req.we && sel_i[0];
	wire hit_ctrl = req.addr == ASP_CTRL_OFF;
	wire hit_buf = req.addr == ASP_BUF_OFF;
	wire hit_stat = req.addr == ASP_STAT_OFF;
	wire hit_mask = req.addr == ASP_MASK_OFF;
	wire wr_ctrl = wr_go && hit_ctrl;
	wire wr_buf = wr_go && hit_buf;
	wire wr_stat = wr_go && hit_stat;
	wire wr_mask = wr_go && hit_mask;

	logic [31:0] rd_data;
	always_comb begin
		if (hit_ctrl) begin
			rd_data = {26'h0, ctrl_reg};
		end else if (hit_buf) begin
			rd_data = {24'h0, rbuf_reg};
		end else if (hit_stat) begin
			rd_data = {30'h0, stat_reg};
		end else if (hit_mask) begin
			rd_data = {30'h0, mask_reg};
		end else begin
			rd_data = 32'h0;
		end
	end

	// ----------------------------------------
	// Baud clock and divide-by-16 counters
	// ----------------------------------------
	// Fixed mode: prescale clk by 1 or 2 before /16 gives clk/16 or clk/32
	logic [4:0] pre_reg;
	wire ten_mode = ctrl_reg.mode == ASP_MODE_TEN;
	wire eleven = !ten_mode;
	wire [4:0] pre_top = ctrl_reg.half_rate ? ASP_SLOW_DIV : ASP_FAST_DIV;
	wire pre_roll = pre_reg == pre_top;
	wire tick16 = (ctrl_reg.mode == ASP_MODE_ELEVEN_FIXED) ? (pre_reg[0] || !ctrl_reg.half_rate)
		: (ctrl_reg.mode == ASP_MODE_ELEVEN_TIMER) ? timer_ovf_i : baud_tick_i;

	// Transmit counter and receive counter are separate: receive realigns on edges
	logic [3:0] txdiv_reg;
	logic [3:0] rxdiv_reg;
	wire tx_roll = tick16 && txdiv_reg == ASP_LAST_STATE;
	wire rx_roll = tick16 && rxdiv_reg == ASP_LAST_STATE;

	// ----------------------------------------
	// Receive pin filter
	// ----------------------------------------
	logic rx_level;
	asp_rx_filter u_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(rxd_i),
		.level_o(rx_level)
	);

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA} asp_tx_state_type;
	asp_tx_state_type tx_state_reg;
	logic [8:0] tsr_reg;
	logic first_shift_reg;
	logic txd_reg;
	wire tx_end = tsr_reg[8:2] == 7'h00 && tsr_reg[1];
	wire tx_finish = tx_state_reg == TX_DATA && tx_roll && tx_end;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_reg <= TX_IDLE;
			tsr_reg <= 9'h000;
			first_shift_reg <= 1'b0;
			txd_reg <= 1'b1;
		end else begin
			case (tx_state_reg)
				TX_IDLE: begin
					txd_reg <= 1'b1;
					if (wr_buf) begin
						// Ninth position: marker one, or software ninth bit
						tsr_reg <= {eleven ? ctrl_reg.tx_ninth_bit : 1'b1, dat_i[7:0]};
						tx_state_reg <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					if (tx_roll) begin
						tx_state_reg <= TX_START;
						txd_reg <= 1'b0;
					end
				end
				TX_START: begin
					if (tx_roll) begin
						tx_state_reg <= TX_DATA;
						txd_reg <= tsr_reg[0];
						first_shift_reg <= 1'b1;
					end
				end
				TX_DATA: begin
					if (tx_roll) begin
						first_shift_reg <= 1'b0;
						// Eleven-bit first shift brings in stop one, then zeros
						tsr_reg <= {eleven && first_shift_reg, tsr_reg[8:1]};
						txd_reg <= tsr_reg[1];
						if (tx_end) begin
							tx_state_reg <= TX_IDLE;
							txd_reg <= 1'b1;
						end
					end
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	typedef enum logic {RX_HUNT, RX_BITS} asp_rx_state_type;
	asp_rx_state_type rx_state_reg;
	logic [8:0] rsr_reg;
	logic [2:0] smp_reg;
	logic first_bit_reg;
	logic prev_level_reg;

	// Falling edge seen on the sixteen-times sample tick
	wire rx_fall = rx_state_reg == RX_HUNT && tick16 && prev_level_reg && !rx_level;
	wire bit_val = (smp_reg[0] & smp_reg[1]) | (smp_reg[1] & smp_reg[2])
		| (smp_reg[0] & smp_reg[2]);
	wire rx_last = rx_state_reg == RX_BITS && rx_roll && !rsr_reg[0];
	// Start bit at bit zero means the bit now sampled, not shifted in, is the stop bit or the ninth bit
	wire rx_accept = rx_last && !stat_reg[ASP_ST_RX_BIT]
		&& (!ctrl_reg.multiproc_mode || bit_val);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_reg <= RX_HUNT;
			rsr_reg <= ASP_RX_PRESET;
			smp_reg <= 3'h0;
			first_bit_reg <= 1'b0;
			prev_level_reg <= 1'b1;
			rbuf_reg <= 8'h00;
		end else begin
			if (tick16) begin
				prev_level_reg <= rx_level;
			end
			case (rx_state_reg)
				RX_HUNT: begin
					if (rx_fall) begin
						rx_state_reg <= RX_BITS;
						rsr_reg <= ASP_RX_PRESET;
						first_bit_reg <= 1'b1;
					end
				end
				RX_BITS: begin
					if (tick16 && rxdiv_reg == ASP_SAMPLE_A) begin
						smp_reg[0] <= rx_level;
					end
					if (tick16 && rxdiv_reg == ASP_SAMPLE_B) begin
						smp_reg[1] <= rx_level;
					end
					if (tick16 && rxdiv_reg == ASP_SAMPLE_C) begin
						smp_reg[2] <= rx_level;
					end
					if (rx_roll) begin
						first_bit_reg <= 1'b0;
						if (first_bit_reg && bit_val) begin
							rx_state_reg <= RX_HUNT;
						end else if (rx_last) begin
							rx_state_reg <= RX_HUNT;
							if (rx_accept) begin
								rbuf_reg <= rsr_reg[8:1];
							end
						end else begin
							rsr_reg <= {bit_val, rsr_reg[8:1]};
						end
					end
				end
				default: rx_state_reg <= RX_HUNT;
			endcase
		end
	end

	// ----------------------------------------
	// Counters, control and flags
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_reg <= 5'h00;
			txdiv_reg <= 4'h0;
			rxdiv_reg <= 4'h0;
		end else begin
			pre_reg <= pre_roll ? 5'h00 : pre_reg + 5'h01;
			if (tick16) begin
				txdiv_reg <= txdiv_reg + 4'h1;
			end
			if (rx_fall) begin
				rxdiv_reg <= 4'h0;
			end else if (tick16) begin
				rxdiv_reg <= rxdiv_reg + 4'h1;
			end
		end
	end

	// Hardware set wins over a software clear in the same cycle
	wire [1:0] stat_set = {rx_accept, tx_finish};
	wire [1:0] stat_clr = wr_stat ? dat_i[1:0] : 2'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= ASP_CTRL_RESET;
			stat_reg <= ASP_STAT_RESET;
			mask_reg <= ASP_MASK_RESET;
			irq_reg <= 1'b0;
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end else begin
			ack_reg <= bus_go;
			dat_reg <= bus_go ? rd_data : 32'h0;
			stat_reg <= (stat_reg & ~stat_clr) | stat_set;
			irq_reg <= |(((stat_reg & ~stat_clr) | stat_set) & mask_reg);
			if (wr_mask) begin
				mask_reg <= dat_i[1:0];
			end
			if (wr_ctrl) begin
				ctrl_reg <= dat_i[5:0];
			end
			if (rx_accept) begin
				// Bit sampled at the last rollover, not shifted in: stop bit, or the ninth data bit in eleven-bit frames
				ctrl_reg.rx_ninth_bit <= bit_val;
			end
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
	assign txd_o = txd_reg;
	assign irq_o = irq_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	tx_idle_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_state_reg == TX_IDLE && $past(tx_state_reg) == TX_IDLE |-> txd_o)
		else $error("txd not idle high");
	tx_start_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_state_reg == TX_START |-> !txd_o)
		else $error("start bit not low");
	tx_done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_finish |=> stat_reg[ASP_ST_TX_BIT] && tx_state_reg == TX_IDLE)
		else $error("tx done not set");
	rx_preset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_fall |=> rsr_reg == ASP_RX_PRESET && rxdiv_reg == 4'h0)
		else $error("receive not realigned");
	rx_false_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_roll && first_bit_reg && bit_val && rx_state_reg == RX_BITS
		|=> rx_state_reg == RX_HUNT)
		else $error("false start kept");
	rx_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_last |=> rx_state_reg == RX_HUNT)
		else $error("receiver not hunting");
	rx_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_last && stat_reg[ASP_ST_RX_BIT] |=> $stable(rbuf_reg))
		else $error("buffer overwritten");
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stat_reg[ASP_ST_RX_BIT] && !wr_stat |=> stat_reg[ASP_ST_RX_BIT])
		else $error("rx done lost");

	// Frame shape and receive loading
	tx_wait_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_state_reg == TX_WAIT |-> txd_o)
		else $error("line left idle level before rollover");
	tx_stop_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_finish |=> txd_o)
		else $error("stop bit not high");
	tx_first_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_state_reg == TX_DATA && tx_roll && first_shift_reg && eleven |=> tsr_reg[8])
		else $error("stop one not shifted in");
	rx_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_accept |=> rbuf_reg == $past(rsr_reg[8:1]) && stat_reg[ASP_ST_RX_BIT])
		else $error("receive buffer not loaded");
	rx_ninth_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_accept |=> ctrl_reg.rx_ninth_bit == $past(bit_val))
		else $error("ninth bit not stored");

endmodule

/* File: verification/asp_remote.sv */
// Remote serial node model: frame sender on the receive pin, monitor on the transmit pin
module asp_remote
	import asp_pkg::*;
(
	// Clock and frame shape
	input wire logic clk_i,
	input wire logic [7:0] bit_clks_i,
	input wire logic [3:0] frame_bits_i,
	// Serial lines
	input wire logic txd_i,
	output logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [10:0] seen_frame;
	int frames_seen = 0;

	// Idle line rests high
	initial rxd_o = 1'b1;

	// ----------------------------------------
	// Sender
	// ----------------------------------------
	// Start zero, data LSB first, optional ninth, stop one
	task automatic send(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_o <= bits[i];
			repeat (bit_clks_i) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask

	// Short low pulse, too brief to be a start bit
	task automatic glitch(input int clks);
		rxd_o <= 1'b0;
		repeat (clks) @(posedge clk_i);
		rxd_o <= 1'b1;
	endtask

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	// Mid-bit sampling keeps clear of edge jitter
	always begin
		@(negedge txd_i);
		seen_frame = '0;
		repeat (bit_clks_i / 2) @(posedge clk_i);
		for (int i = 0; i < frame_bits_i; i++) begin
			seen_frame[i] = txd_i;
			repeat (bit_clks_i) @(posedge clk_i);
		end
		frames_seen++;
	end
endmodule

/* File: verification/test_async_serial_port_frames.sv */
// Self-checking bench for the asynchronous serial port
module test_async_serial_port_frames
	import asp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i, stb_i, we_i, ack_o, baud_tick_i, timer_ovf_i, rxd, txd_o, irq_o;
	logic [1:0] tdiv = 2'h0;
	logic [3:0] adr_i, sel_i, fb;
	logic [31:0] dat_i, dat_o, rd;
	logic [7:0] bit_clks, dv;
	logic [5:0] cfg [4] = '{6'h00, 6'h09, 6'h21, 6'h0a};
	logic [7:0] clks [4] = '{8'h40, 8'h10, 8'h20, 8'h40};
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	int n0, t0;

	asp_core uut(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.baud_tick_i(baud_tick_i), .timer_ovf_i(timer_ovf_i), .rxd_i(rxd), .txd_o(txd_o),
		.irq_o(irq_o));
	asp_remote remote(.clk_i(clk_i), .bit_clks_i(bit_clks), .frame_bits_i(fb),
		.txd_i(txd_o), .rxd_o(rxd));

	always #50 clk_i = ~clk_i;

	// Sixteen-times ticks every fourth clock, plus the hang guard
	always @(posedge clk_i) begin
		tdiv <= tdiv + 2'h1;
		baud_tick_i <= (tdiv == 2'h3);
		timer_ovf_i <= (tdiv == 2'h3);
		cycles++;
		if (cycles == 40000) begin
			fails++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= v;
		sel_i <= s;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		wb(1'b1, a, v, 4'hf);
	endtask

	task automatic rg(input logic [3:0] a);
		wb(1'b0, a, 32'h0, 4'hf);
	endtask

	task automatic wait_irq(input logic lvl);
		int n = 0;
		while (irq_o !== lvl && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		check(irq_o, lvl);
	endtask

	function automatic logic [10:0] frame(input logic [7:0] v, input logic nine, input logic [3:0] n);
		return (n == 4'ha) ? {2'b01, v, 1'b0} : {1'b1, nine, v, 1'b0};
	endfunction

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{cyc_i, stb_i, we_i} = 3'h0;
		{adr_i, sel_i, dat_i} = '0;
		bit_clks = 8'h40;
		fb = 4'ha;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 16; a += 4) begin
			rg(4'(a));
			check(rd, 32'h0);
		end
		rg(4'h2);
		check(rd, 32'h0);
		wb(1'b1, ASP_MASK_OFF, 32'h3, 4'he);
		rg(ASP_MASK_OFF);
		check(rd, 32'h0);
		wr(ASP_MASK_OFF, 32'h3);
		$display("reset and bus test done");
		for (int i = 0; i < 4; i++) begin
			wr(ASP_CTRL_OFF, 32'(cfg[i]));
			bit_clks = clks[i];
			fb = (cfg[i][1:0] == 2'h0) ? 4'ha : 4'hb;
			dv = 8'ha5 + 8'h25 * 8'(i);
			n0 = remote.frames_seen;
			wr(ASP_BUF_OFF, 32'(dv));
			t0 = cycles;
			wait_irq(1'b1);
			check({31'h0, cycles - t0 >= (int'(fb) - 1) * int'(bit_clks)
				&& cycles - t0 <= int'(fb) * int'(bit_clks) + 4}, 32'h1);
			rg(ASP_STAT_OFF);
			check(rd, 32'h1);
			while (remote.frames_seen == n0) @(posedge clk_i);
			check(remote.seen_frame, frame(dv, cfg[i][3], fb));
			wr(ASP_STAT_OFF, 32'h1);
			wait_irq(1'b0);
			remote.send(frame(~dv, ~cfg[i][3], fb), int'(fb));
			wait_irq(1'b1);
			rg(ASP_STAT_OFF);
			check(rd, 32'h2);
			rg(ASP_BUF_OFF);
			check(rd, {24'h0, ~dv});
			rg(ASP_CTRL_OFF);
			check({31'h0, rd[4]}, {31'h0, (fb == 4'ha) ? 1'b1 : ~cfg[i][3]});
			wr(ASP_STAT_OFF, 32'h2);
			$display("mode %0d transfer test done", i);
		end
		wr(ASP_CTRL_OFF, 32'h0);
		bit_clks = 8'h40;
		fb = 4'ha;
		remote.glitch(16);
		repeat (800) @(posedge clk_i);
		rg(ASP_STAT_OFF);
		check(rd, 32'h0);
		remote.send(frame(8'h81, 1'b1, fb), 10);
		wait_irq(1'b1);
		rg(ASP_BUF_OFF);
		check(rd, 32'h81);
		remote.send(frame(8'h7e, 1'b1, fb), 10);
		repeat (200) @(posedge clk_i);
		rg(ASP_BUF_OFF);
		check(rd, 32'h81);
		wr(ASP_MASK_OFF, 32'h0);
		wait_irq(1'b0);
		wr(ASP_MASK_OFF, 32'h3);
		wait_irq(1'b1);
		wr(ASP_STAT_OFF, 32'h2);
		wait_irq(1'b0);
		$display("false start, overrun and mask test done");
		wr(ASP_CTRL_OFF, 32'h06);
		fb = 4'hb;
		remote.send(frame(8'h11, 1'b0, fb), 11);
		repeat (200) @(posedge clk_i);
		rg(ASP_STAT_OFF);
		check(rd, 32'h0);
		remote.send(frame(8'h22, 1'b1, fb), 11);
		wait_irq(1'b1);
		rg(ASP_BUF_OFF);
		check(rd, 32'h22);
		$display("multiprocessor test done");
		report_and_stop();
	end
endmodule
